/* src/timer_reload_pkg.sv */
// Constants, field layout and bus carrier type for the auto-reload timer.
package timer_reload_pkg;

   // Register indices; byte address is four times the index.
   localparam logic [7:0] IDX_MODE = 8'hDC;
   localparam logic [7:0] IDX_COUNT = 8'hDD;
   localparam logic [7:0] IDX_RELOAD = 8'hDE;
   localparam logic [7:0] IDX_STATUS = 8'hE0;
   localparam logic [7:0] IDX_MASK = 8'hE1;

   // Timer mode register field positions.
   localparam int MODE_PWM_EN = 0;
   localparam int MODE_RELOAD_SEL = 2;
   localparam int MODE_FAST_CLK = 3;
   localparam int MODE_CODE_LO = 4;
   localparam int MODE_ENABLE = 7;

   // Status and mask bit for the overflow event.
   localparam int STAT_OVF = 0;

   // Values after reset.
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] RELOAD_RST = 8'h00;
   localparam logic [7:0] STAT_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;

   // Reference cycles per CPU clock, and base prescale counts in CPU clock cycles and in reference clock cycles.
   localparam logic [10:0] CPU_DIV = 11'h004;
   localparam logic [10:0] CPU_BASE = 11'h100;
   localparam logic [10:0] OSC_BASE = 11'h080;

   // Overflow boundaries: full 8-bit span, or half span chosen in PWM mode by the reload select bit.
   localparam logic [7:0] BOUND_FULL = 8'hFF;
   localparam logic [7:0] BOUND_HALF = 8'h7F;

   // APB request as driven by the master.
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

endpackage

/* src/timer_reload_prescale.sv */
// Auto-reload 8-bit timer with prescaler, PWM output and APB register access.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
module timer_reload_prescale (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic reset,
   // APB slave.
   input wire timer_reload_pkg::apb_req_t apb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timer outputs.
   output logic pwm_out,
   output logic irq
);
   import timer_reload_pkg::*;

   // Prescale ratio in reference clock cycles for a source and code.
   function automatic logic [10:0] div_ratio(input logic fast, input logic [2:0] code);
      logic [10:0] r;
      r = fast ? (OSC_BASE >> code) : ((CPU_BASE >> code) * CPU_DIV);
      return r;
   endfunction

   // Register index from a byte address; misaligned addresses map nowhere.
   function automatic logic [8:0] reg_index(input logic [11:0] a);
      logic [8:0] i;
      i = (a[1:0] == 2'h0) ? {1'b0, a[9:2]} : 9'h1FF;
      if (a[11:10] != 2'h0) begin
         i = 9'h1FF;
      end
      return i;
   endfunction

   logic [7:0] mode_q;
   logic [7:0] count_q;
   logic [7:0] count_d;
   logic [7:0] reload_q;
   logic [7:0] stat_q;
   logic [7:0] mask_q;
   logic [9:0] pre_q;
   logic [31:0] rdata_q;
   logic pwm_q;

   logic [8:0] idx;
   logic mapped;
   logic wr_acc;
   logic rd_setup;
   logic mode_wr;
   logic count_wr;
   logic tick;
   logic [10:0] ratio;
   logic [2:0] code;
   logic fast_clock_select;
   logic reload_select_bit;
   logic pwm_output_enable;
   logic timer_on;
   logic [7:0] bound;
   logic ovf;
   logic do_reload;

   // Mode field decode.
   assign code = mode_q[MODE_CODE_LO +: 3];
   assign fast_clock_select = mode_q[MODE_FAST_CLK];
   assign reload_select_bit = mode_q[MODE_RELOAD_SEL];
   assign pwm_output_enable = mode_q[MODE_PWM_EN];
   assign timer_on = mode_q[MODE_ENABLE];

   // Bus decode; the slave answers in the first access cycle, so pready stays high.
   assign idx = reg_index(apb.paddr);
   assign mapped = (idx == {1'b0, IDX_MODE}) || (idx == {1'b0, IDX_COUNT})
      || (idx == {1'b0, IDX_RELOAD}) || (idx == {1'b0, IDX_STATUS})
      || (idx == {1'b0, IDX_MASK});
   assign wr_acc = apb.psel && apb.penable && apb.pwrite && mapped;
   assign rd_setup = apb.psel && !apb.penable && !apb.pwrite;
   assign mode_wr = wr_acc && (idx == {1'b0, IDX_MODE});
   assign count_wr = wr_acc && (idx == {1'b0, IDX_COUNT});
   assign pready = 1'b1;
   assign pslverr = apb.psel && apb.penable && !mapped;
   assign prdata = rdata_q;

   // Prescaler ratio from source and code.
   assign ratio = div_ratio(fast_clock_select, code);
   assign tick = timer_on && ({1'b0, pre_q} >= (ratio - 11'h001));

   // Overflow boundary: in PWM mode the reload select bit picks half span.
   assign bound = (pwm_output_enable && reload_select_bit) ? BOUND_HALF : BOUND_FULL;
   assign ovf = tick && (count_q == bound);
   // PWM forces reload; otherwise the reload select bit enables it.
   assign do_reload = pwm_output_enable || reload_select_bit;

   // Next count: software write first, then overflow, then plain increment.
   always_comb begin
      count_d = count_q;
      if (count_wr) begin
         count_d = apb.pwdata[7:0];
      end else if (ovf) begin
         count_d = do_reload ? reload_q : 8'h00;
      end else if (tick) begin
         count_d = count_q + 8'h01;
      end
   end

   // Prescale counter; the comparison uses >= so a ratio shrunk mid-count still wraps.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pre_q <= 10'h000;
      end else if (!timer_on || tick) begin
         pre_q <= 10'h000;
      end else begin
         pre_q <= pre_q + 10'h001;
      end
   end

   // Count register.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         count_q <= COUNT_RST;
      end else begin
         count_q <= count_d;
      end
   end

   // Mode register.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mode_q <= MODE_RST;
      end else if (mode_wr) begin
         mode_q <= apb.pwdata[7:0];
      end
   end

   // Reload value register, write-only.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         reload_q <= RELOAD_RST;
      end else if (wr_acc && (idx == {1'b0, IDX_RELOAD})) begin
         reload_q <= apb.pwdata[7:0];
      end
   end

   // Mask register.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mask_q <= MASK_RST;
      end else if (wr_acc && (idx == {1'b0, IDX_MASK})) begin
         mask_q <= apb.pwdata[7:0];
      end
   end

   // Sticky status; a new overflow wins over a write-one clear in the same cycle.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         stat_q <= STAT_RST;
      end else begin
         if (wr_acc && (idx == {1'b0, IDX_STATUS})) begin
            stat_q <= stat_q & ~apb.pwdata[7:0];
         end
         if (ovf) begin
            stat_q[STAT_OVF] <= 1'b1;
         end
      end
   end

   // Read data is captured in the setup cycle and held through the access cycle.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd_setup) begin
         rdata_q <= 32'h0000_0000;
         if (idx == {1'b0, IDX_MODE}) begin
            rdata_q[7:0] <= mode_q;
         end else if (idx == {1'b0, IDX_COUNT}) begin
            rdata_q[7:0] <= count_q;
         end else if (idx == {1'b0, IDX_STATUS}) begin
            rdata_q[7:0] <= stat_q;
         end else if (idx == {1'b0, IDX_MASK}) begin
            rdata_q[7:0] <= mask_q;
         end
      end
   end

   // PWM output: high at wrap, low on match; held low while PWM is off.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pwm_q <= 1'b0;
      end else if (!pwm_output_enable) begin
         pwm_q <= 1'b0;
      end else if (ovf) begin
         pwm_q <= 1'b1;
      end else if (count_q == reload_q) begin
         pwm_q <= 1'b0;
      end
   end

   assign pwm_out = pwm_q;
   // Level interrupt while any unmasked status bit is set.
   assign irq = |(stat_q & mask_q);

   // Checks.
   chk_reload_copy: assert property (@(posedge ref_clk) disable iff (reset)
      (ovf && reload_select_bit && !pwm_output_enable && !count_wr)
      |=> (count_q == $past(reload_q)))
      else $error("Count did not take the reload value on overflow.");

   chk_pwm_reload: assert property (@(posedge ref_clk) disable iff (reset)
      (ovf && pwm_output_enable && !reload_select_bit && !count_wr)
      |=> (count_q == $past(reload_q)))
      else $error("PWM mode overflow did not reload.");

   chk_pwm_boundary: assert property (@(posedge ref_clk) disable iff (reset)
      (tick && pwm_output_enable && reload_select_bit && count_q == 8'h7F && !count_wr)
      |=> (count_q == $past(reload_q)) && stat_q[STAT_OVF])
      else $error("Half span boundary did not overflow.");

   chk_reload_wo: assert property (@(posedge ref_clk) disable iff (reset)
      (apb.psel && apb.penable && !apb.pwrite && idx == {1'b0, IDX_RELOAD})
      |-> (prdata == 32'h0000_0000))
      else $error("Write-only reload register read back nonzero.");

   chk_cpu_div2: assert property (@(posedge ref_clk) disable iff (reset || mode_wr)
      (tick && !fast_clock_select && code == 3'h7)
      |=> (!tick)[*7] ##1 tick)
      else $error("CPU clock by 2 tick spacing wrong.");

   chk_osc_div1: assert property (@(posedge ref_clk) disable iff (reset || mode_wr)
      (tick && fast_clock_select && code == 3'h7) |=> tick)
      else $error("Oscillator by 1 did not tick every cycle.");

   chk_cpu_div64: assert property (@(posedge ref_clk) disable iff (reset)
      (tick && !fast_clock_select && code == 3'h2) |-> (pre_q == 10'h0FF))
      else $error("CPU clock by 64 ratio wrong.");

   chk_osc_div4: assert property (@(posedge ref_clk) disable iff (reset || mode_wr)
      (tick && fast_clock_select && code == 3'h5) |=> (!tick)[*3] ##1 tick)
      else $error("Oscillator by 4 tick spacing wrong.");

   chk_code_field: assert property (@(posedge ref_clk) disable iff (reset)
      mode_wr |=> (code == $past(apb.pwdata[6:4])))
      else $error("Prescale code not taken from bits 4 to 6.");

   chk_pwm_low: assert property (@(posedge ref_clk) disable iff (reset)
      (pwm_output_enable && !ovf && count_q == reload_q && !mode_wr) |=> !pwm_out)
      else $error("PWM output not low on match.");

   chk_pwm_high: assert property (@(posedge ref_clk) disable iff (reset)
      (pwm_output_enable && ovf && !mode_wr) |=> pwm_out)
      else $error("PWM output not high after wrap.");

endmodule
`default_nettype wire

/* tb/timer_reload_prescale_bench.sv */
// Self-checking bench for the auto-reload timer with prescaler and APB registers.
`timescale 1ns/1ns
`default_nettype none
module timer_reload_prescale_bench;
   import timer_reload_pkg::*;
   logic ref_clk, reset, pready, pslverr, pwm_out, irq, err;
   logic [31:0] prdata, rd;
   logic [31:0] seed = 32'h9;
   apb_req_t apb;
   int n_fail = 0, n_checks = 0, cyc = 0, t0, per, hi = 0, hi0;
   // Cases: prescale code, fast clock select, reload select, PWM enable, reload base.
   int tb[10][5] = '{'{7, 0, 1, 0, 'hE0}, '{2, 0, 1, 0, 'hF8}, '{0, 0, 1, 0, 'hFC},
      '{7, 0, 0, 0, 'hE0}, '{5, 1, 1, 0, 'hE0}, '{6, 1, 1, 0, 'hE0}, '{7, 1, 1, 0, 'hE0},
      '{0, 1, 1, 0, 'hF0}, '{7, 0, 0, 1, 'hE0}, '{7, 0, 1, 1, 'h60}};

   timer_reload_prescale DUT (.ref_clk(ref_clk), .reset(reset), .apb(apb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out), .irq(irq));

   // Free-running clock and a cycle count used to time the overflows.
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) cyc <= cyc + 1;
   // Cycles with the PWM output high, sampled mid-cycle where it is settled.
   always @(negedge ref_clk) if (pwm_out === 1'b1) hi <= hi + 1;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Overflow period in reference clocks; without reload the count wraps to zero.
   function automatic int period(int code, int fast, int rsel, int pwm, int rl);
      int ratio = fast ? (128 >> code) : 4 * (256 >> code);
      int bnd = (pwm && rsel) ? 127 : 255;
      return ratio * (bnd - ((pwm || rsel) ? rl : 0) + 1);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; an idle edge first keeps back-to-back calls from racing.
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      @(posedge ref_clk);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'b00, idx, 2'b00},
         pwdata: {24'h000000, wd}};
      @(posedge ref_clk);
      apb.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_fail++;
         $display("Error at %0t: bus transfer got no ready", $time);
      end
      rd = prdata;
      err = pslverr;
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
   endtask

   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (irq !== 1'b1 && n < lim);
      if (n >= lim) begin
         n_fail++;
         $display("Error at %0t: interrupt did not arrive", $time);
      end
   endtask

   task automatic summarize();
      if (n_fail == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Main sequence: registers, timer periods per mode, then interrupt masking.
   initial begin
      reset = 1'b1;
      apb = '0;
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      bus(1'b1, IDX_RELOAD, 8'hA5);
      bus(1'b0, IDX_RELOAD, 8'h00);
      chk(rd, 32'h0);
      bus(1'b1, 8'h10, 8'h5A);
      chk({31'h0, err}, 32'h1);
      bus(1'b1, IDX_MASK, 8'h01);
      for (int i = 0; i < 10; i++) begin
         logic [7:0] rl;
         rl = 8'(tb[i][4]) | 8'(rnd() & 32'hF);
         bus(1'b1, IDX_MODE, 8'h00);
         bus(1'b1, IDX_RELOAD, rl);
         bus(1'b1, IDX_COUNT, rl);
         bus(1'b1, IDX_STATUS, 8'h01);
         bus(1'b1, IDX_MODE, {1'b1, 3'(tb[i][0]), 1'(tb[i][1]), 1'(tb[i][2]), 1'b0,
            1'(tb[i][3])});
         per = period(tb[i][0], tb[i][1], tb[i][2], tb[i][3], int'(rl));
         wait_irq(2 * per + 50);
         t0 = cyc;
         hi0 = hi;
         bus(1'b1, IDX_STATUS, 8'h01);
         wait_irq(2 * per + 50);
         chk(32'(cyc - t0), 32'(per));
         @(negedge ref_clk);
         chk(32'(hi - hi0), 32'(tb[i][3]));
         chk({31'h0, pwm_out}, 32'h0);
      end
      // A masked overflow must set status but keep the interrupt line low.
      bus(1'b1, IDX_MODE, 8'h00);
      bus(1'b1, IDX_MASK, 8'h00);
      bus(1'b1, IDX_STATUS, 8'h01);
      bus(1'b1, IDX_COUNT, 8'hFE);
      bus(1'b1, IDX_MODE, 8'hF8);
      repeat (20) @(posedge ref_clk);
      bus(1'b1, IDX_MODE, 8'h00);
      bus(1'b0, IDX_STATUS, 8'h00);
      chk(rd, 32'h1);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, IDX_MASK, 8'h01);
      @(negedge ref_clk);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, IDX_STATUS, 8'h01);
      @(negedge ref_clk);
      chk({31'h0, irq}, 32'h0);
      summarize();
   end

   // Watchdog sized well above the longest expected run.
   initial begin
      repeat (90000) @(posedge ref_clk);
      n_fail++;
      summarize();
   end
endmodule
`default_nettype wire
